// >>> src/rfc_consts.vh
// Constants for the reading filter chain: register map, fields, resets, timing.
`ifndef RFC_CONSTS_VH
`define RFC_CONSTS_VH

// Register byte offsets on the AXI4-Lite bus.
`define RFC_REG_CTRL       8'h00
`define RFC_REG_TOGGLE     8'h04
`define RFC_REG_LC_COUNT   8'h08
`define RFC_REG_MEDIAN_CFG 8'h0C
`define RFC_REG_MEAN_CFG   8'h10
`define RFC_REG_STATUS     8'h14
`define RFC_REG_LAST       8'h18
`define RFC_REG_INTEG      8'h1C

// Field positions.
`define RFC_BIT_MEDIAN_EN  0
`define RFC_BIT_MEAN_EN    1
`define RFC_BIT_MOVING     2
`define RFC_BIT_ADVANCED   3
`define RFC_NTOL_LSB       8

// Reset values and limits; line cycle count is in hundredths of a cycle.
`define RFC_LC_DEF60       13'h0258
`define RFC_LC_DEF50       13'h01F4
`define RFC_LC_MAX60       13'h1770
`define RFC_LC_MAX50       13'h1388
`define RFC_LC_MIN         13'h0001
`define RFC_LC_MEDIUM      13'h0064
`define RFC_LC_FAST        13'h000A
`define RFC_RANK_DEF       3'h1
`define RFC_RANK_MAX       3'h5
`define RFC_COUNT_DEF      7'h0A
`define RFC_COUNT_MAX      7'h64
`define RFC_NTOL_DEF       7'h00
`define RFC_NTOL_MAX       7'h69
`define RFC_WIN_MAX        11
`define RFC_STACK_MAX      100

// Reading counts that make one percent of full range.
`define RFC_PCT_COUNTS     22'h004E20

// Timing: line cycle lengths in ns, clock period in ns.
`define RFC_LC60_NS        16670000
`define RFC_LC50_NS        20000000
`define RFC_CLK_NS         20
`define RFC_CLK_PER_HUND60 (`RFC_LC60_NS / (`RFC_CLK_NS * 100))
`define RFC_CLK_PER_HUND50 (`RFC_LC50_NS / (`RFC_CLK_NS * 100))

`define RFC_RESP_OKAY      2'h0
`define RFC_RESP_SLVERR    2'h2

`endif

// >>> src/rfc_reading_filter.v
// Reading filter chain: rate setting, median stage, mean stage, AXI4-Lite regs.
`timescale 1ns/100ps
`default_nettype none
`include "rfc_consts.vh"

module rfc_reading_filter (
  input  wire        clk,
  input  wire        rst,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output wire [1:0]  s_axi_bresp,
  output wire        s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output wire [31:0] s_axi_rdata,
  output wire [1:0]  s_axi_rresp,
  output wire        s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        rd_valid,
  input  wire [31:0] rd_data,
  input  wire [2:0]  range_sel,
  input  wire        zero_check,
  input  wire        line_50hz,
  output wire        out_valid,
  output wire [31:0] out_data,
  output wire        rate_slow,
  output wire        rate_medium,
  output wire        rate_fast,
  output wire        filter_active,
  output wire [12:0] lc_count,
  output wire [25:0] integ_clocks
);

  reg         bvalid_q, rvalid_q;
  reg  [1:0]  bresp_q, rresp_q;
  reg  [31:0] rdata_q;
  reg         sync1_q, sync2_q, init_q;
  reg         median_en_q, mean_en_q, moving_q, adv_q;
  reg  [12:0] lc_q;
  reg  [2:0]  rank_q;
  reg  [6:0]  count_q, ntol_q;
  reg  [2:0]  range_q;
  reg  [25:0] integ_q;
  reg  signed [31:0] mbuf [0:`RFC_WIN_MAX-1];
  reg  [3:0]  mcnt_q;
  reg         mpend_q;
  reg  signed [31:0] abuf [0:`RFC_STACK_MAX-1];
  reg  signed [39:0] sum_q;
  reg  [6:0]  held_q, wp_q;
  reg  signed [31:0] mean_q;
  reg         out_valid_q;
  reg  [31:0] out_data_q;
  integer     k;
  integer     mk;
  integer     sk;

  wire        wr_fire = s_axi_awvalid & s_axi_wvalid & ~bvalid_q;
  wire        rd_fire = s_axi_arvalid & ~rvalid_q;
  wire        mapped_w = (s_axi_awaddr[7:5] == 3'h0) &
                         (s_axi_awaddr[1:0] == 2'h0);
  wire        mapped_r = (s_axi_araddr[7:5] == 3'h0) &
                         (s_axi_araddr[1:0] == 2'h0);

  assign s_axi_awready = wr_fire;
  assign s_axi_wready  = wr_fire;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ~rvalid_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;

  // Indicators compare the exact stored setting, never a rounded rate.
  wire [12:0] lc_slow = sync2_q ? `RFC_LC_DEF50 : `RFC_LC_DEF60;
  wire [12:0] lc_max  = sync2_q ? `RFC_LC_MAX50 : `RFC_LC_MAX60;
  assign rate_slow     = (lc_q == lc_slow);
  assign rate_medium   = (lc_q == `RFC_LC_MEDIUM);
  assign rate_fast     = (lc_q == `RFC_LC_FAST);
  assign filter_active = median_en_q | mean_en_q;
  assign lc_count      = lc_q;
  assign integ_clocks  = integ_q;
  assign out_valid     = out_valid_q;
  assign out_data      = out_data_q;

  function [31:0] reg_at;
    input [7:0] a;
    begin
      case (a)
        `RFC_REG_CTRL:       reg_at = {28'h000_0000, adv_q, moving_q,
                                       mean_en_q, median_en_q};
        `RFC_REG_LC_COUNT:   reg_at = {19'h0_0000, lc_q};
        `RFC_REG_MEDIAN_CFG: reg_at = {29'h0000_0000, rank_q};
        `RFC_REG_MEAN_CFG:   reg_at = {17'h0_0000, ntol_q, 1'b0, count_q};
        `RFC_REG_STATUS:     reg_at = {9'h000, held_q, 4'h0, mcnt_q, 3'h0,
                                       sync2_q, filter_active, rate_fast,
                                       rate_medium, rate_slow};
        `RFC_REG_LAST:       reg_at = out_data_q;
        `RFC_REG_INTEG:      reg_at = {6'h00, integ_q};
        default:             reg_at = 32'h0000_0000;
      endcase
    end
  endfunction

  // Byte lanes merge onto the current contents before range clamping.
  reg  [31:0] wm;
  always @* begin
    wm = reg_at(s_axi_awaddr);
    for (k = 0; k < 4; k = k + 1) begin
      if (s_axi_wstrb[k]) begin
        wm[k*8 +: 8] = s_axi_wdata[k*8 +: 8];
      end
    end
  end

  wire [12:0] lc_w    = (wm[12:0] < `RFC_LC_MIN) ? `RFC_LC_MIN :
                        (wm[12:0] > lc_max) ? lc_max : wm[12:0];
  wire [2:0]  rank_w  = (wm[2:0] == 3'h0) ? 3'h1 :
                        (wm[2:0] > `RFC_RANK_MAX) ? `RFC_RANK_MAX : wm[2:0];
  wire [6:0]  count_w = (wm[6:0] == 7'h00) ? 7'h01 :
                        (wm[6:0] > `RFC_COUNT_MAX) ? `RFC_COUNT_MAX :
                        wm[6:0];
  wire [6:0]  ntol_w  = (wm[14:8] > `RFC_NTOL_MAX) ? `RFC_NTOL_MAX :
                        wm[14:8];

  wire wr_ctrl = wr_fire & (s_axi_awaddr == `RFC_REG_CTRL);
  wire wr_tog  = wr_fire & (s_axi_awaddr == `RFC_REG_TOGGLE);
  wire wr_mcfg = wr_fire & (s_axi_awaddr == `RFC_REG_MEDIAN_CFG);
  wire wr_acfg = wr_fire & (s_axi_awaddr == `RFC_REG_MEAN_CFG);
  wire range_chg = (range_sel != range_q);
  wire median_rs = zero_check | range_chg | wr_ctrl |
                   (wr_tog & s_axi_wstrb[0] & s_axi_wdata[0]) |
                   wr_mcfg;
  wire mean_rs   = zero_check | range_chg | wr_ctrl |
                   (wr_tog & s_axi_wstrb[0] & s_axi_wdata[1]) |
                   wr_acfg;

  // Per-hundredth clock counts derived from the line cycle lengths.
  localparam [31:0] PER_HUND60 = `RFC_CLK_PER_HUND60;
  localparam [31:0] PER_HUND50 = `RFC_CLK_PER_HUND50;
  wire [13:0] per_hund = sync2_q ? PER_HUND50[13:0] : PER_HUND60[13:0];
  wire [26:0] integ_c  = lc_q * per_hund;

  // Strap synchroniser; left out of reset so it has settled at release.
  always @(posedge clk) begin
    sync1_q <= line_50hz;
    sync2_q <= sync1_q;
  end

  always @(posedge clk) begin
    if (rst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= `RFC_RESP_OKAY;
      rvalid_q <= 1'b0;
      rresp_q  <= `RFC_RESP_OKAY;
      rdata_q  <= 32'h0000_0000;
      init_q   <= 1'b1;
      median_en_q <= 1'b0;
      mean_en_q   <= 1'b0;
      moving_q    <= 1'b0;
      adv_q       <= 1'b0;
      lc_q        <= `RFC_LC_DEF60;
      rank_q      <= `RFC_RANK_DEF;
      count_q     <= `RFC_COUNT_DEF;
      ntol_q      <= `RFC_NTOL_DEF;
      range_q     <= 3'h0;
      integ_q     <= 26'h000_0000;
    end else begin
      range_q <= range_sel;
      integ_q <= integ_c[25:0];
      // The synchroniser runs through reset, so the strap is trusted at
      // release as long as reset was held for at least two clocks.
      if (init_q) begin
        init_q <= 1'b0;
        lc_q   <= lc_slow;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q  <= mapped_w ? `RFC_RESP_OKAY : `RFC_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_q <= 1'b0;
      end
      if (rd_fire) begin
        rvalid_q <= 1'b1;
        rdata_q  <= reg_at(s_axi_araddr);
        rresp_q  <= mapped_r ? `RFC_RESP_OKAY : `RFC_RESP_SLVERR;
      end else if (s_axi_rready) begin
        rvalid_q <= 1'b0;
      end
      if (wr_ctrl) begin
        median_en_q <= wm[`RFC_BIT_MEDIAN_EN];
        mean_en_q   <= wm[`RFC_BIT_MEAN_EN];
        moving_q    <= wm[`RFC_BIT_MOVING];
        adv_q       <= wm[`RFC_BIT_ADVANCED];
      end
      if (wr_tog & s_axi_wstrb[0]) begin
        median_en_q <= median_en_q ^ s_axi_wdata[0];
        mean_en_q   <= mean_en_q ^ s_axi_wdata[1];
      end
      if (wr_fire & (s_axi_awaddr == `RFC_REG_LC_COUNT)) begin
        init_q <= 1'b0;
        lc_q   <= lc_w;
      end
      if (wr_mcfg) begin
        rank_q <= rank_w;
      end
      if (wr_acfg) begin
        count_q <= count_w;
        ntol_q  <= ntol_w;
      end
    end
  end

  // Median stage: the window is ranked fresh for every output.
  wire [3:0] win = {rank_q, 1'b1};
  wire [`RFC_WIN_MAX-1:0] msel;
  genvar gi;
  generate
    for (gi = 0; gi < `RFC_WIN_MAX; gi = gi + 1) begin : g_rank
      reg [3:0] lt;
      reg [3:0] eq;
      integer   j;
      always @* begin
        lt = 4'h0;
        eq = 4'h0;
        for (j = 0; j < `RFC_WIN_MAX; j = j + 1) begin
          if (j < win) begin
            if (mbuf[j] < mbuf[gi]) begin
              lt = lt + 4'h1;
            end else if (mbuf[j] == mbuf[gi]) begin
              eq = eq + 4'h1;
            end
          end
        end
      end
      assign msel[gi] = (gi < win) & ({1'b0, rank_q} >= lt) &
                        ((lt + eq) > {1'b0, rank_q});
    end
  endgenerate

  reg signed [31:0] median_c;
  always @* begin
    median_c = 32'h0000_0000;
    for (sk = 0; sk < `RFC_WIN_MAX; sk = sk + 1) begin
      if (msel[sk]) begin
        median_c = mbuf[sk];
      end
    end
  end

  always @(posedge clk) begin
    if (rst | median_rs) begin
      mcnt_q  <= 4'h0;
      mpend_q <= 1'b0;
    end else if (rd_valid & median_en_q) begin
      for (mk = `RFC_WIN_MAX - 1; mk > 0; mk = mk - 1) begin
        mbuf[mk] <= mbuf[mk-1];
      end
      mbuf[0] <= rd_data;
      mcnt_q  <= (mcnt_q >= win) ? win : mcnt_q + 4'h1;
      mpend_q <= ((mcnt_q + 4'h1) >= win);
    end else begin
      mpend_q <= 1'b0;
    end
  end

  // Mean stage input: the median result when that stage runs, else raw.
  wire               m_v = median_en_q ? (mpend_q & ~median_rs) :
                                         rd_valid;
  wire signed [31:0] m_x = median_en_q ? median_c : rd_data;
  wire signed [39:0] x40 = {{8{m_x[31]}}, m_x};
  wire signed [39:0] mean40 = {{8{mean_q[31]}}, mean_q};
  wire signed [39:0] dif = x40 - mean40;
  wire [39:0] adif = dif[39] ? -dif : dif;
  wire [28:0] thr  = ntol_q * `RFC_PCT_COUNTS;
  wire jump = adv_q & (held_q != 7'h00) &
              (adif > {11'h000, thr});
  wire signed [31:0] oldest = abuf[wp_q];
  wire [6:0] wp_inc  = wp_q + 7'h01;
  wire [6:0] wp_next = (wp_inc >= count_q) ? 7'h00 : wp_inc;

  reg signed [39:0] nsum;
  reg        [6:0]  nheld;
  always @* begin
    if (jump) begin
      nsum  = x40;
      nheld = 7'h01;
    end else if (moving_q & (held_q >= count_q)) begin
      nsum  = sum_q + x40 - {{8{oldest[31]}}, oldest};
      nheld = held_q;
    end else begin
      nsum  = sum_q + x40;
      nheld = held_q + 7'h01;
    end
  end

  // One-cycle divide keeps the stage simple at the cost of a long path.
  wire signed [39:0] quot = nsum / $signed({33'h0_0000_0000, nheld});
  wire full_rep = ~moving_q & (nheld >= count_q);
  wire emit = moving_q | jump | full_rep;

  always @(posedge clk) begin
    if (rst | mean_rs) begin
      sum_q  <= 40'h00_0000_0000;
      held_q <= 7'h00;
      wp_q   <= 7'h00;
      mean_q <= 32'h0000_0000;
    end else if (m_v & mean_en_q) begin
      mean_q <= quot[31:0];
      if (full_rep) begin
        sum_q  <= 40'h00_0000_0000;
        held_q <= 7'h00;
      end else begin
        sum_q  <= nsum;
        held_q <= nheld;
      end
      if (jump) begin
        abuf[0] <= m_x;
        wp_q    <= (count_q == 7'h01) ? 7'h00 : 7'h01;
      end else if (moving_q) begin
        abuf[wp_q] <= m_x;
        wp_q       <= wp_next;
      end
    end
  end

  always @(posedge clk) begin
    if (rst) begin
      out_valid_q <= 1'b0;
      out_data_q  <= 32'h0000_0000;
    end else begin
      out_valid_q <= m_v & ~mean_rs & (~mean_en_q | emit);
      if (m_v & ~mean_rs & (~mean_en_q | emit)) begin
        out_data_q <= mean_en_q ? quot[31:0] : m_x;
      end
    end
  end

endmodule
`default_nettype wire

// >>> verification/rfc_conv_model.sv
// Behavioural model of the integrating converter that feeds readings.
`timescale 1ns/100ps
`default_nettype none
module rfc_conv_model (
  input  wire logic        clk,
  output var  logic        rd_valid,
  output var  logic [31:0] rd_data
);
  initial begin
    rd_valid = 1'b0;
    rd_data = 32'h0000_0000;
  end

  // One reading per call: a single-cycle pulse after g+1 idle cycles.
  task automatic send(input logic [31:0] v, input int g);
    repeat (g) @(posedge clk);
    @(posedge clk);
    rd_valid <= 1'b1;
    rd_data <= v;
    @(posedge clk);
    rd_valid <= 1'b0;
    // Idle data is inverted so a stale value can never pass as a reading.
    rd_data <= ~v;
  endtask
endmodule
`default_nettype wire

// >>> verification/rfc_filter_chk.sv
// Port-level assertions for the reading filter chain.
`timescale 1ns/100ps
`default_nettype none
`include "rfc_consts.vh"
module rfc_filter_chk (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        rd_valid,
  input wire logic        line_50hz,
  input wire logic        out_valid,
  input wire logic [31:0] out_data,
  input wire logic        rate_slow,
  input wire logic        rate_medium,
  input wire logic        rate_fast,
  input wire logic [12:0] lc_count,
  input wire logic [25:0] integ_clocks
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_wr_take;
    s_axi_awvalid && s_axi_wvalid && s_axi_awready;
  endsequence
  sequence s_wr_done;
    s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endsequence

  a_wr_answer: assert property (s_wr_take |=> s_wr_done)
    else $error("write response missing after accepted write");
  a_wr_refuse: assert property (s_axi_bvalid |-> !s_axi_wready)
    else $error("write data accepted while response pending");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data missing after accepted read");
  a_rate_match: assert property (!line_50hz |->
      {rate_slow, rate_medium, rate_fast} == {lc_count == `RFC_LC_DEF60,
      lc_count == `RFC_LC_MEDIUM, lc_count == `RFC_LC_FAST})
    else $error("rate indicator disagrees with line cycle count");
  a_rate_slow50: assert property (line_50hz |->
      rate_slow == (lc_count == `RFC_LC_DEF50))
    else $error("slow indicator disagrees at 50Hz line");
  a_rate_single: assert property (
      $onehot0({rate_slow, rate_medium, rate_fast}))
    else $error("more than one rate indicator lit");
  a_lc_range: assert property (!line_50hz |->
      lc_count >= `RFC_LC_MIN && lc_count <= `RFC_LC_MAX60)
    else $error("line cycle count outside legal range");
  a_integ_time: assert property (!line_50hz && !$past(rst) |->
      integ_clocks == $past(lc_count) * 26'h208F)
    else $error("integration clocks do not match line cycle count");
  a_out_cause: assert property (out_valid |->
      $past(rd_valid) || $past(rd_valid, 2))
    else $error("filtered reading without a recent input reading");
  a_out_hold: assert property (!out_valid && !$past(rst) |->
      $stable(out_data))
    else $error("output data changed without output strobe");
endmodule
bind rfc_reading_filter rfc_filter_chk chk (.clk, .rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .rd_valid, .line_50hz,
  .out_valid, .out_data, .rate_slow, .rate_medium, .rate_fast, .lc_count,
  .integ_clocks);
`default_nettype wire

// >>> verification/tb.sv
// Self-checking testbench for the reading filter chain.
`timescale 1ns/100ps
`default_nettype none
`include "rfc_consts.vh"
module tb;
  typedef struct packed {
    logic [31:0] w;
    logic [12:0] lc;
    logic [2:0]  f;
  } rfc_lc_row_t;
  logic        clk, rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, zero_check, line_50hz;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, rd_valid, out_valid, filter_active;
  logic        rate_slow, rate_medium, rate_fast;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  range_sel;
  logic [12:0] lc_count;
  logic [25:0] integ_clocks;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd_data, out_data;
  logic [31:0] last_out = 32'h0000_0000;
  int          num_errors, n_compared;
  int          n_out = 0;
  rfc_lc_row_t rows [8] = '{'{32'h0000_0064, 13'h0064, 3'h2},
    '{32'h0000_000A, 13'h000A, 3'h1}, '{32'h0000_00C8, 13'h00C8, 3'h0},
    '{32'h0000_0000, 13'h0001, 3'h0}, '{32'h0000_1770, 13'h1770, 3'h0},
    '{32'h0000_1F40, 13'h1770, 3'h0}, '{32'h0000_0001, 13'h0001, 3'h0},
    '{32'h0000_0258, 13'h0258, 3'h4}};

  rfc_reading_filter dut (.clk, .rst, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .rd_valid, .rd_data, .range_sel, .zero_check, .line_50hz, .out_valid,
    .out_data, .rate_slow, .rate_medium, .rate_fast, .filter_active,
    .lc_count, .integ_clocks);
  rfc_conv_model conv (.clk, .rd_valid, .rd_data);

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  always @(posedge clk) begin
    if (out_valid === 1'b1) begin
      n_out <= n_out + 1;
      last_out <= out_data;
    end
  end

  task automatic finish_test;
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Handshake levels are sampled at the falling edge so the decision
  // never races the rising edge that completes the transfer.
  task automatic hs(input int s, output logic [31:0] d, output logic [1:0] r);
    logic t;
    for (int i = 0; i < 20; i++) begin
      @(negedge clk);
      t = (s == 0) ? s_axi_awready : (s == 1) ? s_axi_bvalid :
          (s == 2) ? s_axi_arready : s_axi_rvalid;
      d = s_axi_rdata;
      r = (s == 1) ? s_axi_bresp : s_axi_rresp;
      @(posedge clk);
      if (t === 1'b1) return;
    end
    num_errors++;
    $display("MISMATCH handshake %0d expected done seen timeout", s);
    finish_test;
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] v,
                     input logic [1:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    hs(0, d, r);
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    hs(1, d, r);
    s_axi_bready <= 1'b0;
    chk("bresp", e, r);
  endtask

  task automatic axr(input logic [7:0] a, input logic [31:0] v,
                     input logic [1:0] e);
    logic [31:0] d;
    logic [1:0]  r;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    hs(2, d, r);
    s_axi_arvalid <= 1'b0;
    hs(3, d, r);
    s_axi_rready <= 1'b0;
    chk("rresp", e, r);
    chk("rdata", v, d);
  endtask

  // Sends readings, alternating prompt and slow spacing, then checks
  // the outputs produced during this call.
  task automatic feed(input logic [31:0] q[$], input int n,
                      input logic [31:0] v);
    int          n0;
    logic [31:0] l0;
    n0 = n_out;
    l0 = last_out;
    foreach (q[k]) conv.send(q[k], k % 2);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("out_count", n, n_out - n0);
    chk("out_data", (n == 0) ? l0 : v, last_out);
  endtask

  initial begin
    rst = 1'b1;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready, zero_check, line_50hz} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, range_sel} = 19'h0_0000;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    {num_errors, n_compared} = '0;
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("lc_count", `RFC_LC_DEF60, lc_count);
    chk("filter_active", 32'h0000_0000, filter_active);
    axr(`RFC_REG_MEAN_CFG, 32'h0000_000A, `RFC_RESP_OKAY);
    axr(`RFC_REG_MEDIAN_CFG, 32'h0000_0001, `RFC_RESP_OKAY);
    axr(`RFC_REG_CTRL, 32'h0000_0000, `RFC_RESP_OKAY);
    foreach (rows[i]) begin
      range_sel <= 3'(i);
      axw(`RFC_REG_LC_COUNT, rows[i].w, `RFC_RESP_OKAY);
      @(negedge clk);
      chk("lc_count", rows[i].lc, lc_count);
      chk("rate", rows[i].f, {rate_slow, rate_medium, rate_fast});
      axr(`RFC_REG_LC_COUNT, rows[i].lc, `RFC_RESP_OKAY);
    end
    axw(8'h20, 32'h0000_0001, `RFC_RESP_SLVERR);
    axr(8'h20, 32'h0000_0000, `RFC_RESP_SLVERR);
    axw(`RFC_REG_TOGGLE, 32'h0000_0001, `RFC_RESP_OKAY);
    @(negedge clk);
    chk("filter_active", 32'h0000_0001, filter_active);
    axr(`RFC_REG_CTRL, 32'h0000_0001, `RFC_RESP_OKAY);
    feed('{32'h0000_0014, 32'h0000_0001}, 0, 32'h0000_0000);
    feed('{32'h0000_0003}, 1, 32'h0000_0003);
    range_sel <= 3'h2;
    feed('{32'h0000_0007, 32'h0000_0008}, 0, 32'h0000_0000);
    feed('{32'h0000_0009}, 1, 32'h0000_0008);
    axw(`RFC_REG_MEDIAN_CFG, 32'h0000_0005, `RFC_RESP_OKAY);
    feed('{32'h0000_0000, 32'h0000_0007, 32'h0000_0003, 32'h0000_000A,
      32'h0000_0006, 32'h0000_0002, 32'h0000_0009, 32'h0000_0005,
      32'h0000_0001, 32'h0000_0008}, 0, 32'h0000_0000);
    feed('{32'h0000_0004}, 1, 32'h0000_0005);
    axw(`RFC_REG_MEDIAN_CFG, 32'h0000_0001, `RFC_RESP_OKAY);
    axw(`RFC_REG_MEAN_CFG, 32'h0000_0002, `RFC_RESP_OKAY);
    axw(`RFC_REG_CTRL, 32'h0000_0007, `RFC_RESP_OKAY);
    feed('{32'h0000_0014, 32'h0000_0001, 32'h0000_0003, 32'h0000_0007,
      32'h0000_0008}, 3, 32'h0000_0005);
    axw(`RFC_REG_CTRL, 32'h0000_0006, `RFC_RESP_OKAY);
    feed('{32'h0000_0004}, 1, 32'h0000_0004);
    feed('{32'h0000_0008, 32'h0000_000C}, 2, 32'h0000_000A);
    axw(`RFC_REG_MEAN_CFG, 32'h0000_0003, `RFC_RESP_OKAY);
    axw(`RFC_REG_CTRL, 32'h0000_0002, `RFC_RESP_OKAY);
    feed('{32'h0000_0003, 32'h0000_0006, 32'h0000_0009}, 1,
      32'h0000_0006);
    feed('{32'h0000_000A, 32'h0000_0014}, 0, 32'h0000_0000);
    zero_check <= 1'b1;
    @(posedge clk);
    zero_check <= 1'b0;
    feed('{32'h0000_001E, 32'h0000_0021, 32'h0000_0024}, 1,
      32'h0000_0021);
    axw(`RFC_REG_MEAN_CFG, 32'h0000_0104, `RFC_RESP_OKAY);
    axw(`RFC_REG_CTRL, 32'h0000_000E, `RFC_RESP_OKAY);
    feed('{32'h0000_0064, 32'h0000_00C8}, 2, 32'h0000_0096);
    feed('{32'h0001_86A0}, 1, 32'h0001_86A0);
    feed('{32'h0001_8704}, 1, 32'h0001_86D2);
    axr(`RFC_REG_LAST, 32'h0001_86D2, `RFC_RESP_OKAY);
    axw(`RFC_REG_CTRL, 32'h0000_0000, `RFC_RESP_OKAY);
    @(negedge clk);
    chk("filter_active", 32'h0000_0000, filter_active);
    // Second reset with the 50Hz strap: the slow setting must follow it.
    line_50hz <= 1'b1;
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("lc_count", `RFC_LC_DEF50, lc_count);
    chk("rate", 32'h0000_0004, {rate_slow, rate_medium, rate_fast});
    chk("out_data", 32'h0000_0000, out_data);
    axw(`RFC_REG_LC_COUNT, 32'h0000_1770, `RFC_RESP_OKAY);
    axr(`RFC_REG_LC_COUNT, 32'h0000_1388, `RFC_RESP_OKAY);
    axw(`RFC_REG_LC_COUNT, 32'h0000_01F4, `RFC_RESP_OKAY);
    axr(`RFC_REG_INTEG, 32'h004C_4B40, `RFC_RESP_OKAY);
    finish_test;
  end
endmodule
`default_nettype wire
